// ---- core/irq_event_defines.svh ----
// Purpose: constants of the vector, return and arrival-event command decoder
// Assumes: included by the package and the decoder only
// Notes:   reply status codes beyond 100 and 128 are local picks
`ifndef IRQ_EVENT_DEFINES_SVH
`define IRQ_EVENT_DEFINES_SVH
// instruction codes
`define OP_IRQ_ENABLE     8'h19
`define OP_IRQ_DISABLE    8'h1A
`define OP_DEFINE_VECTOR  8'h25
`define OP_RETURN_IRQ     8'h26
`define OP_USER_FIRST     8'h40
`define OP_USER_LAST      8'h47
`define OP_POS_REACHED    8'h8A
// interrupt numbering
`define IRQ_COUNT         16
`define IRQ_IDX_W         4
`define IRQ_GLOBAL        8'hFF
// reply status codes
`define STAT_OK           8'h64
`define STAT_ARRIVED      8'h80
`define STAT_BAD_CSUM     8'h01
`define STAT_BAD_CMD      8'h02
`define STAT_BAD_TYPE     8'h03
`define STAT_BAD_VALUE    8'h04
`define STAT_NOT_DIRECT   8'h06
// addresses and fields
`define MODULE_ADDR       8'h01
`define HOST_ADDR         8'h02
`define AXIS_MASK         32'h0000_0001
`define ARRIVE_ONCE_TYPE  8'h00
`define ARRIVE_EVERY_TYPE 8'h01
`endif

// ---- core/irq_event_pkg.sv ----
// Purpose: types for the vector, return and arrival-event command decoder
// Assumes: defines header already provides numeric constants
// Notes:   arrival state codes are gray along idle, once, every
`include "irq_event_defines.svh"
package irq_event_pkg;
   typedef enum logic [1:0] {
      ARR_IDLE  = 2'b00,
      ARR_ONCE  = 2'b01,
      ARR_EVERY = 2'b11
   } arrive_e;

   // modulo-256 sum of eight frame bytes
   function automatic logic [7:0] sum8(input logic [7:0] b0, input logic [7:0] b1,
                                       input logic [7:0] b2, input logic [7:0] b3,
                                       input logic [31:0] v);
      logic [7:0] s;
      s = b0 + b1 + b2 + b3 + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      return s;
   endfunction
endpackage

// ---- core/irq_vector_event_cmd.sv ----
// Purpose: decode vector, return-from-interrupt, user and arrival-event commands
// Assumes: frames arrive whole on one strobe from logic on the same clock
// Notes:   replies are registered; an arrival reply yields to an immediate one
`include "irq_event_defines.svh"

// Contract
// - code 37 stores label per interrupt
// - return restores accumulator, X, flags, counter
// - return ends active handler
// - return accepted only in stored program
// - user functions answer status 100
// - code 138 gives immediate and arrival reply
// - code 138 only as host command
// - value is motor mask, must be 1
// - type 0 next move, 1 every move
// - frame order address through checksum
// - immediate reply status 64h, command 8Ah
// - arrival reply status 80h, command 8Ah
// - number 255 switches interrupts globally
// - redefining a vector replaces entry
module irq_vector_event_cmd (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   // command frame, one-cycle strobe
   input  wire logic        cmd_valid_i,
   input  wire logic        cmd_from_prog_i,
   input  wire logic [7:0]  cmd_addr_i,
   input  wire logic [7:0]  cmd_instr_i,
   input  wire logic [7:0]  cmd_type_i,
   input  wire logic [7:0]  cmd_bank_i,
   input  wire logic [31:0] cmd_value_i,
   input  wire logic [7:0]  cmd_csum_i,
   // interpreter context
   input  wire logic        irq_slot_i,
   input  wire logic [15:0] irq_req_i,
   input  wire logic [31:0] pc_i,
   input  wire logic [31:0] accu_i,
   input  wire logic [31:0] xreg_i,
   input  wire logic [7:0]  flags_i,
   // motion events
   input  wire logic        move_start_i,
   input  wire logic        target_reached_i,
   // program counter load and context restore
   output logic             pc_load_o,
   output logic [31:0]      pc_load_val_o,
   output logic             ctx_restore_o,
   output logic [31:0]      accu_o,
   output logic [31:0]      xreg_o,
   output logic [7:0]       flags_o,
   output logic             in_handler_o,
   output logic             irq_global_en_o,
   // reply frame, one-cycle strobe
   output logic             reply_valid_o,
   output logic [7:0]       reply_host_o,
   output logic [7:0]       reply_module_o,
   output logic [7:0]       reply_status_o,
   output logic [7:0]       reply_cmd_o,
   output logic [31:0]      reply_value_o,
   output logic [7:0]       reply_csum_o
);
   localparam int N = `IRQ_COUNT;
   logic [31:0]           vec_q [N];
   logic [N-1:0]          vec_ok_q;
   logic [N-1:0]          irq_en_q;
   logic                  glob_en_q;
   logic                  in_handler_q;
   logic [31:0]           sv_pc_q, sv_accu_q, sv_x_q;
   logic [7:0]            sv_flags_q;
   irq_event_pkg::arrive_e arr_q;
   logic                  move_pend_q;
   logic                  arr_send_q;
   // frame check and decode
   logic csum_ok, addr_ok, direct, take, is_define_vector_cmd, is_return_from_irq_cmd, is_ena, is_dis, is_user, is_pos;
   logic [`IRQ_IDX_W-1:0] tidx;
   assign csum_ok = irq_event_pkg::sum8(cmd_addr_i, cmd_instr_i, cmd_type_i, cmd_bank_i,
                                        cmd_value_i) == cmd_csum_i;
   assign addr_ok = cmd_addr_i == `MODULE_ADDR;
   assign take    = cmd_valid_i && addr_ok && (csum_ok || cmd_from_prog_i);
   assign direct  = take && !cmd_from_prog_i;
   assign tidx    = cmd_type_i[`IRQ_IDX_W-1:0];
   assign is_define_vector_cmd = cmd_instr_i == `OP_DEFINE_VECTOR;
   assign is_return_from_irq_cmd = cmd_instr_i == `OP_RETURN_IRQ;
   assign is_ena  = cmd_instr_i == `OP_IRQ_ENABLE;
   assign is_dis  = cmd_instr_i == `OP_IRQ_DISABLE;
   assign is_user = cmd_instr_i >= `OP_USER_FIRST && cmd_instr_i <= `OP_USER_LAST;
   assign is_pos  = cmd_instr_i == `OP_POS_REACHED;
   logic type_in_range, pos_ok, return_from_irq_cmd_go;
   assign type_in_range = cmd_type_i < 8'(N);
   assign pos_ok  = cmd_value_i == `AXIS_MASK &&
                    (cmd_type_i == `ARRIVE_ONCE_TYPE || cmd_type_i == `ARRIVE_EVERY_TYPE);
   assign return_from_irq_cmd_go = take && is_return_from_irq_cmd && cmd_from_prog_i && in_handler_q;
   // interrupt pick: lowest pending source that is enabled and has a vector
   logic [N-1:0]          ready_irq;
   logic                  irq_go;
   logic [`IRQ_IDX_W-1:0] pick;
   assign ready_irq = irq_req_i & irq_en_q & vec_ok_q;
   assign irq_go    = irq_slot_i && glob_en_q && !in_handler_q && |ready_irq && !return_from_irq_cmd_go;
   always_comb begin
      pick = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (ready_irq[i]) begin
            pick = i[`IRQ_IDX_W-1:0];
         end
      end
   end
   // vector table, one entry per interrupt source
   for (genvar g = 0; g < N; g++) begin : g_vec
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            vec_q[g]    <= 32'h0000_0000;
            vec_ok_q[g] <= 1'b0;
            irq_en_q[g] <= 1'b0;
         end else begin
            if (take && is_define_vector_cmd && tidx == g && type_in_range) begin
               vec_q[g]    <= cmd_value_i;
               vec_ok_q[g] <= 1'b1;
            end
            if (take && is_ena && cmd_type_i == 8'(g)) begin
               irq_en_q[g] <= 1'b1;
            end else if (take && is_dis && cmd_type_i == 8'(g)) begin
               irq_en_q[g] <= 1'b0;
            end
         end
      end
   end
   // global interrupt switch
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         glob_en_q <= 1'b0;
      end else if (take && is_ena && cmd_type_i == `IRQ_GLOBAL) begin
         glob_en_q <= 1'b1;
      end else if (take && is_dis && cmd_type_i == `IRQ_GLOBAL) begin
         glob_en_q <= 1'b0;
      end
   end
   // handler entry saves context, return restores it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_handler_q  <= 1'b0;
         sv_pc_q       <= 32'h0000_0000;
         sv_accu_q     <= 32'h0000_0000;
         sv_x_q        <= 32'h0000_0000;
         sv_flags_q    <= 8'h00;
         pc_load_o     <= 1'b0;
         pc_load_val_o <= 32'h0000_0000;
         ctx_restore_o <= 1'b0;
         accu_o        <= 32'h0000_0000;
         xreg_o        <= 32'h0000_0000;
         flags_o       <= 8'h00;
      end else begin
         pc_load_o     <= irq_go || return_from_irq_cmd_go;
         ctx_restore_o <= return_from_irq_cmd_go;
         if (irq_go) begin
            in_handler_q  <= 1'b1;
            sv_pc_q       <= pc_i;
            sv_accu_q     <= accu_i;
            sv_x_q        <= xreg_i;
            sv_flags_q    <= flags_i;
            pc_load_val_o <= vec_q[pick];
         end else if (return_from_irq_cmd_go) begin
            in_handler_q  <= 1'b0;
            pc_load_val_o <= sv_pc_q;
            accu_o        <= sv_accu_q;
            xreg_o        <= sv_x_q;
            flags_o       <= sv_flags_q;
         end
      end
   end
   assign in_handler_o    = in_handler_q;
   assign irq_global_en_o = glob_en_q;
   // arrival arming; a new request in the start cycle wins over the once-clear
   logic arm_req;
   assign arm_req = direct && is_pos && pos_ok;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arr_q       <= irq_event_pkg::ARR_IDLE;
         move_pend_q <= 1'b0;
      end else begin
         if (arm_req) begin
            arr_q <= cmd_type_i[0] ? irq_event_pkg::ARR_EVERY : irq_event_pkg::ARR_ONCE;
         end else if (move_start_i && arr_q == irq_event_pkg::ARR_ONCE) begin
            arr_q <= irq_event_pkg::ARR_IDLE;
         end
         if (move_start_i && arr_q != irq_event_pkg::ARR_IDLE) begin
            move_pend_q <= 1'b1;
         end else if (target_reached_i) begin
            move_pend_q <= 1'b0;
         end
      end
   end
   // arrival reply waits while any immediate reply holds the port, bad sum included
   logic arr_fire;
   assign arr_fire = (target_reached_i && move_pend_q) || arr_send_q;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arr_send_q <= 1'b0;
      end else begin
         arr_send_q <= arr_fire && cmd_valid_i && addr_ok && !cmd_from_prog_i;
      end
   end
   // reply status selection for direct commands
   logic [7:0] stat;
   always_comb begin
      if (!csum_ok) begin
         stat = `STAT_BAD_CSUM;
      end else if (is_return_from_irq_cmd) begin
         stat = `STAT_NOT_DIRECT;
      end else if (is_pos) begin
         stat = pos_ok ? `STAT_OK : `STAT_BAD_VALUE;
      end else if (is_define_vector_cmd) begin
         stat = type_in_range ? `STAT_OK : `STAT_BAD_TYPE;
      end else if (is_ena || is_dis || is_user) begin
         stat = `STAT_OK;
      end else begin
         stat = `STAT_BAD_CMD;
      end
   end
   // reply frame; a bad checksum still gets an answer
   logic        rep_now;
   logic [31:0] rep_val;
   assign rep_now = cmd_valid_i && addr_ok && !cmd_from_prog_i;
   assign rep_val = (is_pos && csum_ok) ? (cmd_value_i & `AXIS_MASK) : 32'h0000_0000;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reply_valid_o  <= 1'b0;
         reply_host_o   <= 8'h00;
         reply_module_o <= 8'h00;
         reply_status_o <= 8'h00;
         reply_cmd_o    <= 8'h00;
         reply_value_o  <= 32'h0000_0000;
         reply_csum_o   <= 8'h00;
      end else begin
         reply_valid_o  <= rep_now || arr_fire;
         reply_host_o   <= `HOST_ADDR;
         reply_module_o <= `MODULE_ADDR;
         if (rep_now) begin
            reply_status_o <= stat;
            reply_cmd_o    <= cmd_instr_i;
            reply_value_o  <= rep_val;
            reply_csum_o   <= irq_event_pkg::sum8(`HOST_ADDR, `MODULE_ADDR, stat,
                                                  cmd_instr_i, rep_val);
         end else if (arr_fire) begin
            reply_status_o <= `STAT_ARRIVED;
            reply_cmd_o    <= `OP_POS_REACHED;
            reply_value_o  <= `AXIS_MASK;
            reply_csum_o   <= irq_event_pkg::sum8(`HOST_ADDR, `MODULE_ADDR, `STAT_ARRIVED,
                                                  `OP_POS_REACHED, `AXIS_MASK);
         end
      end
   end
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_enter;
      irq_go ##1 pc_load_o;
   endsequence
   sequence s_leave;
      return_from_irq_cmd_go ##1 (ctx_restore_o && !in_handler_q);
   endsequence
   chk_vector_store: assert property (take && is_define_vector_cmd && type_in_range |=>
      vec_q[$past(tidx)] == $past(cmd_value_i) && vec_ok_q[$past(tidx)])
      else $error("vector not stored");
   chk_return_restore: assert property (return_from_irq_cmd_go |=> pc_load_val_o == $past(sv_pc_q)
      && accu_o == $past(sv_accu_q) && flags_o == $past(sv_flags_q))
      else $error("context not restored");
   chk_return_leave: assert property (return_from_irq_cmd_go |-> s_leave)
      else $error("handler not left");
   chk_direct_return: assert property (direct && is_return_from_irq_cmd |=> !ctx_restore_o
      && reply_status_o == `STAT_NOT_DIRECT) else $error("direct return obeyed");
   chk_user_ok: assert property (direct && csum_ok && is_user |=>
      reply_valid_o && reply_status_o == `STAT_OK) else $error("user status wrong");
   chk_arrival_reply: assert property (move_pend_q && target_reached_i && !rep_now |=>
      reply_valid_o && reply_status_o == `STAT_ARRIVED && reply_cmd_o == `OP_POS_REACHED)
      else $error("arrival reply wrong");
   chk_arrival_late: assert property (move_pend_q && target_reached_i && rep_now
      ##1 !rep_now |=> reply_valid_o && reply_status_o == `STAT_ARRIVED)
      else $error("arrival lost");
   chk_prog_no_arm: assert property (take && cmd_from_prog_i && is_pos &&
      arr_q == irq_event_pkg::ARR_IDLE |=> arr_q == irq_event_pkg::ARR_IDLE)
      else $error("armed from program");
   chk_once_clear: assert property (!arm_req && move_start_i &&
      arr_q == irq_event_pkg::ARR_ONCE |=> arr_q == irq_event_pkg::ARR_IDLE && move_pend_q)
      else $error("once mode not cleared");
   chk_global_en: assert property (take && is_ena && cmd_type_i == `IRQ_GLOBAL |=>
      glob_en_q && $stable(irq_en_q)) else $error("global enable wrong");
   chk_entry_save: assert property (irq_go |-> s_enter ##0 (sv_pc_q == $past(pc_i)
      && in_handler_q)) else $error("context not saved");
   chk_reply_csum: assert property (reply_valid_o |-> reply_csum_o ==
      irq_event_pkg::sum8(reply_host_o, reply_module_o, reply_status_o, reply_cmd_o,
                          reply_value_o)) else $error("reply checksum wrong");
endmodule

// ---- testbench/host_model.sv ----
// Purpose: host side that builds whole command frames for the decoder
// Assumes: one frame per call, strobe held for exactly one clock
// Notes:   idle address, code, type, value and checksum show the inverse of the last frame; bank and prog hold
module host_model (
   // clock
   input  wire logic        clk_i,
   // command frame
   output logic             valid_o,
   output logic             prog_o,
   output logic [7:0]       addr_o,
   output logic [7:0]       instr_o,
   output logic [7:0]       type_o,
   output logic [7:0]       bank_o,
   output logic [31:0]      value_o,
   output logic [7:0]       csum_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // quiet bus at time zero
   initial begin
      valid_o = 1'b0;
      prog_o  = 1'b0;
      addr_o  = 8'h00;
      instr_o = 8'h00;
      type_o  = 8'h00;
      bank_o  = 8'h00;
      value_o = 32'h0000_0000;
      csum_o  = 8'h00;
   end

   // one frame: address, code, type, bank, value msb first, checksum
   task automatic send(input logic prog, input logic [7:0] instr, input logic [7:0] typ,
                       input logic [31:0] val, input logic [7:0] spoil);
      @(posedge clk_i);
      #1;
      valid_o = 1'b1;
      prog_o  = prog;
      addr_o  = 8'h01;
      instr_o = instr;
      type_o  = typ;
      bank_o  = 8'h00;
      value_o = val;
      // spoil lets a scenario corrupt the sum on purpose
      csum_o  = addr_o + instr + typ + bank_o + val[31:24] + val[23:16]
                + val[15:8] + val[7:0] + spoil;
      @(posedge clk_i);
      #1;
      valid_o = 1'b0;
      // released fields flip so a late sample cannot pass by luck
      addr_o  = ~addr_o;
      instr_o = ~instr_o;
      type_o  = ~type_o;
      value_o = ~value_o;
      csum_o  = ~csum_o;
   endtask
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench of the vector, return, user and arrival commands
// Assumes: decoder answers one clock after a frame or an event
// Notes:   programs end every handler with a return frame
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        core_clk_i = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic        cv, cp, irq_slot, mv, tr;
   logic [7:0]  ca, ci, ct, cb, cs, flags;
   logic [31:0] cval, pc, accu, xreg;
   logic [15:0] irq_req;
   logic        pl, cr, inh, gen, rv;
   logic [31:0] plv, ao, xo, rval;
   logic [7:0]  fo, rh, rm, rst, rc, rcs;
   int          bad_count = 0;
   int          checks_done = 0;
   int          cycles = 0;

   // clock and hang guard
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles > 3000) begin
         bad_count++;
         end_sim();
      end
   end

   host_model i_host (.clk_i(core_clk_i), .valid_o(cv), .prog_o(cp), .addr_o(ca),
      .instr_o(ci), .type_o(ct), .bank_o(cb), .value_o(cval), .csum_o(cs));

   irq_vector_event_cmd i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
      .cmd_valid_i(cv), .cmd_from_prog_i(cp), .cmd_addr_i(ca), .cmd_instr_i(ci),
      .cmd_type_i(ct), .cmd_bank_i(cb), .cmd_value_i(cval), .cmd_csum_i(cs),
      .irq_slot_i(irq_slot), .irq_req_i(irq_req), .pc_i(pc), .accu_i(accu),
      .xreg_i(xreg), .flags_i(flags), .move_start_i(mv), .target_reached_i(tr),
      .pc_load_o(pl), .pc_load_val_o(plv), .ctx_restore_o(cr), .accu_o(ao),
      .xreg_o(xo), .flags_o(fo), .in_handler_o(inh), .irq_global_en_o(gen),
      .reply_valid_o(rv), .reply_host_o(rh), .reply_module_o(rm),
      .reply_status_o(rst), .reply_cmd_o(rc), .reply_value_o(rval), .reply_csum_o(rcs));

   task automatic end_sim();
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic p, input logic [7:0] i, input logic [7:0] t,
                       input logic [31:0] v, input logic [7:0] spoil);
      i_host.send(p, i, t, v, spoil);
   endtask

   // reply strobe and status only
   task automatic chk_st(input logic [7:0] st);
      chk(rv, 1'b1);
      chk(rst, st);
   endtask

   // full reply frame, sum worked out here
   task automatic reply(input logic [7:0] st, input logic [31:0] v);
      logic [7:0] s;
      s = 8'h03 + st + 8'h8A + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      chk_st(st);
      chk({rh, rm, rc}, 24'h02018A);
      chk(rval, v);
      chk(rcs, s);
   endtask

   // one started move that later arrives
   task automatic move();
      @(posedge core_clk_i);
      #1 mv = 1'b1;
      @(posedge core_clk_i);
      #1 mv = 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1 tr = 1'b1;
      @(posedge core_clk_i);
      #1 tr = 1'b0;
   endtask

   task automatic t_user();
      for (int k = 0; k < 8; k++) begin
         send(1'b0, 8'h40 + 8'(k), 8'h00, 32'h0, 8'h00);
         chk_st(8'h64);
      end
      send(1'b0, 8'h40, 8'h00, 32'h0, 8'h01);
      chk_st(8'h01);
      send(1'b0, 8'h20, 8'h00, 32'h0, 8'h00);
      chk_st(8'h02);
      send(1'b0, 8'h25, 8'h10, 32'h60, 8'h00);
      chk_st(8'h03);
   endtask

   task automatic t_direct_return();
      send(1'b0, 8'h26, 8'h00, 32'h0, 8'h00);
      chk_st(8'h06);
      chk(pl, 1'b0);
      send(1'b1, 8'h26, 8'h00, 32'h0, 8'h00);
      chk({rv, pl, inh}, 3'b000);
   endtask

   task automatic t_vector();
      send(1'b0, 8'h25, 8'h03, 32'h40, 8'h00);
      chk_st(8'h64);
      send(1'b0, 8'h25, 8'h03, 32'h50, 8'h00);
      send(1'b0, 8'h19, 8'h03, 32'h0, 8'h00);
      send(1'b0, 8'h19, 8'hFF, 32'h0, 8'h00);
      chk(gen, 1'b1);
      {pc, accu, xreg, flags} = {32'h1234, 32'hA5, 32'h5A, 8'h3C};
      irq_req  = 16'h0008;
      irq_slot = 1'b1;
      @(posedge core_clk_i);
      #1 irq_slot = 1'b0;
      irq_req = 16'h0000;
      chk({pl, inh}, 2'b11);
      chk(plv, 32'h50);
      {pc, accu, xreg, flags} = {32'h9, 32'h1, 32'h2, 8'h4};
      // handler body ends with a return frame
      send(1'b1, 8'h26, 8'h00, 32'h0, 8'h00);
      chk({pl, cr, inh, rv}, 4'b1100);
      chk(plv, 32'h1234);
      chk(ao, 32'hA5);
      chk(xo, 32'h5A);
      chk(fo, 8'h3C);
      // a source switched off alone must not be taken
      send(1'b0, 8'h1A, 8'h03, 32'h0, 8'h00);
      irq_req  = 16'h0008;
      irq_slot = 1'b1;
      @(posedge core_clk_i);
      #1 irq_slot = 1'b0;
      irq_req = 16'h0000;
      chk({pl, inh}, 2'b00);
      send(1'b0, 8'h1A, 8'hFF, 32'h0, 8'h00);
      chk(gen, 1'b0);
   endtask

   task automatic t_arrival();
      send(1'b1, 8'h8A, 8'h01, 32'h1, 8'h00);
      chk(rv, 1'b0);
      move();
      chk(rv, 1'b0);
      send(1'b0, 8'h8A, 8'h01, 32'h2, 8'h00);
      chk_st(8'h04);
      send(1'b0, 8'h8A, 8'h02, 32'h1, 8'h00);
      chk_st(8'h04);
      send(1'b0, 8'h8A, 8'h00, 32'h1, 8'h00);
      reply(8'h64, 32'h1);
      move();
      reply(8'h80, 32'h1);
      move();
      chk(rv, 1'b0);
      send(1'b0, 8'h8A, 8'h01, 32'h1, 8'h00);
      reply(8'h64, 32'h1);
      for (int k = 0; k < 2; k++) begin
         move();
         reply(8'h80, 32'h1);
      end
   endtask

   // arrival in the cycle of a frame, good sum then bad sum
   task automatic t_collide();
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk_i);
         #1 mv = 1'b1;
         @(posedge core_clk_i);
         #1 mv = 1'b0;
         fork
            send(1'b0, 8'h41, 8'h00, 32'h0, 8'(k));
            begin
               @(posedge core_clk_i);
               #1 tr = 1'b1;
               @(posedge core_clk_i);
               #1 tr = 1'b0;
            end
         join
         chk_st(k == 0 ? 8'h64 : 8'h01);
         @(posedge core_clk_i);
         #1;
         reply(8'h80, 32'h1);
      end
   endtask

   // main sequence
   initial begin
      {irq_slot, mv, tr, irq_req} = '0;
      {pc, accu, xreg, flags} = '0;
      repeat (20) @(posedge core_clk_i);
      #1 reset_n_i = 1'b1;
      t_user();
      t_direct_return();
      t_vector();
      t_arrival();
      t_collide();
      end_sim();
   end
endmodule
